// ==== hw/adc_ctrl_map.svh ====
// Register map and timing constants of the converter control block.
// Included by the design modules and the bench; definitions only.
`ifndef ADC_CTRL_MAP_SVH
`define ADC_CTRL_MAP_SVH

`define OFS_CTRL_ZERO 8'hD6
`define OFS_CTRL_ONE 8'hD7
`define OFS_RESULT_LO 8'hD8
`define OFS_RESULT_HI 8'hD9
`define OFS_STATUS 8'hDA

// converter_control_zero fields
`define C0_CH_LSB 0
`define C0_MODE 3
`define C0_GROUP 4
`define C0_TRIG 5
`define C0_START 6
`define C0_CKLOW 7
// converter_control_one fields
`define C1_RES 3
`define C1_CKHIGH 4
`define C1_REF 5

`define CTRL_ZERO_RESET 8'h00
`define CTRL_ONE_RESET 8'h00
`define CTRL_ONE_WMASK 8'h38

// Converter clock periods in system clocks
`define DIV_F1 8'h01
`define DIV_F2 8'h02
`define DIV_F4 8'h04
// Converter clock cycles per conversion
`define CONV_CYC_8 8'h31
`define CONV_CYC_10 8'h3B

// Reference settling, 1 us at 100 MHz
`define REF_SETTLE_NS 1000
`define CLK_PERIOD_NS 10
`define REF_SETTLE_CYC ((`REF_SETTLE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

// ==== hw/adc_ctrl_pkg.sv ====
// Types shared by the converter control modules.
// Assumes the constants header alongside it.
package adc_ctrl_pkg;
    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } bus_req_s;

    typedef struct packed {
        logic [2:0] channel;
        logic group_en;
        logic trig_timer;
        logic res_ten;
        logic [7:0] div;
    } conv_cfg_s;

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_WAIT_TRIG,
        ST_CONVERT
    } conv_state_e;
endpackage

// ==== hw/adc_clock_gen.sv ====
// Converter clock tick generator: one pulse per converter clock period.
// Assumes a divider value of 1, 2 or 4 system clocks.
`timescale 1ns/1ps
`default_nettype none
`include "adc_ctrl_map.svh"
module adc_clock_gen (
    // Clock and reset
    input wire logic clock,
    input wire logic rstn,
    // Control
    input wire logic run,
    input wire logic [7:0] div,
    // Tick out
    output logic tick
);
    import adc_ctrl_pkg::*;

    typedef struct packed {
        logic [7:0] cnt;
        logic tick;
    } gen_s;

    gen_s cur, next_cur;

    always_comb begin
        next_cur = cur;
        next_cur.tick = 1'b0;
        if (!run) begin
            next_cur.cnt = 8'h00;
        end else if (cur.cnt + 8'h01 >= div) begin
            next_cur.cnt = 8'h00;
            next_cur.tick = 1'b1;
        end else begin
            next_cur.cnt = cur.cnt + 8'h01;
        end
    end

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            cur <= '0;
        end else begin
            cur <= next_cur;
        end
    end

    assign tick = cur.tick;
endmodule
`default_nettype wire

// ==== hw/adc_sar_core.sv ====
// Successive approximation sequencer: trials one bit per converter clock
// over the first ten against the comparator input, then counts out the rest.
// Assumes the analog comparator answers within one converter clock.
`timescale 1ns/1ps
`default_nettype none
`include "adc_ctrl_map.svh"
module adc_sar_core (
    // Clock and reset
    input wire logic clock,
    input wire logic rstn,
    // Control
    input wire logic start,
    input wire logic abort,
    input wire logic tick,
    input wire logic res_ten,
    // Comparator
    input wire logic comp_high,
    output logic [9:0] trial,
    // Result
    output logic done,
    output logic [9:0] value
);
    import adc_ctrl_pkg::*;

    typedef struct packed {
        logic busy;
        logic [7:0] cyc;
        logic [3:0] bitno;
        logic [9:0] acc;
        logic done;
    } sar_s;

    sar_s cur, next_cur;

    always_comb begin
        next_cur = cur;
        next_cur.done = 1'b0;
        if (abort) begin
            next_cur.busy = 1'b0;
        end else if (start && !cur.busy) begin
            next_cur.busy = 1'b1;
            next_cur.cyc = 8'h00;
            next_cur.bitno = 4'h9;
            next_cur.acc = 10'h000;
        end else if (cur.busy && tick) begin
            next_cur.cyc = cur.cyc + 8'h01;
            // One bit decided per converter clock until the last
            if (cur.acc[cur.bitno] == 1'b0 && cur.cyc < 8'h0A) begin
                if (comp_high) begin
                    next_cur.acc[cur.bitno] = 1'b1;
                end
                if (cur.bitno != 4'h0) begin
                    next_cur.bitno = cur.bitno - 4'h1;
                end
            end
            if (cur.cyc + 8'h01 >= (res_ten ? `CONV_CYC_10 : `CONV_CYC_8)) begin
                next_cur.busy = 1'b0;
                next_cur.done = 1'b1;
            end
        end
    end

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            cur <= '0;
        end else begin
            cur <= next_cur;
        end
    end

    // R9 8-bit results keep the upper bits only
    assign trial = cur.acc | (10'h001 << cur.bitno);
    assign value = res_ten ? cur.acc : {cur.acc[9:2], 2'b00};
    assign done = cur.done;
endmodule
`default_nettype wire

// ==== hw/adc_control.sv ====
// Converter control top: two control registers, result readback,
// start/stop/repeat sequencing and the one-shot completion request.
// Assumes a synchronous register port and a one-cycle timer request.
// Behaviour
// R1 - Channel codes 100..111 select analog inputs 8 to 11.
// R2 - Channel selection acts only while the input group is enabled.
// R3 - Mode bit 0 gives one-shot, 1 gives repeat.
// R4 - Trigger bit 0 starts on the flag, 1 on timer request.
// R5 - Divider bits pick f4, f2 or f1 converter clock.
// R6 - Software keeps the converter clock at or below 10 MHz; at 100 MHz the dividers 1, 2 and 4 give 100, 50 and 25 MHz.
// R7 - Rewriting control during conversion may spoil the result.
// R8 - Software reselects the channel after changing mode.
// R9 - Resolution bit 0 gives 8 bits, 1 gives 10 bits.
// R10 - Reference connect bit drives the ladder; 1 us settle after.
// R11 - Writing start flag 1 begins, 0 halts conversion.
// R12 - One-shot converts the selected input once per start.
// R13 - One-shot clears the start flag itself on completion.
// R14 - One-shot raises a request at completion; repeat never does.
// R15 - Repeat converts continuously until the flag is cleared.
// R16 - Every completed value is readable from the result register.
// R17 - In repeat, each new value overwrites the previous one.
`timescale 1ns/1ps
`default_nettype none
`include "adc_ctrl_map.svh"
module adc_control (
    // Clock and reset
    input wire logic clock,
    input wire logic rstn,
    // Register port
    input wire adc_ctrl_pkg::bus_req_s bus,
    output logic [7:0] rdata,
    // Timer request, converter comparator
    input wire logic timer_req,
    input wire logic comp_high,
    // Analog front end
    output logic [3:0] input_select,
    output logic [9:0] dac_trial,
    output logic reference_connect,
    output logic ref_ready,
    // Completion request
    output logic conv_irq
);
    import adc_ctrl_pkg::*;

    typedef struct packed {
        logic [7:0] ctrl0;
        logic [7:0] ctrl1;
        logic [9:0] result;
        logic [7:0] rdata;
        logic [3:0] in_sel;
        logic [9:0] trial;
        logic irq;
        logic [7:0] settle;
        logic ready;
        logic fresh;
        conv_state_e state;
    } top_s;

    top_s cur, next_cur;
    logic tick;
    logic sar_done;
    logic [9:0] sar_value;
    logic [9:0] sar_trial;
    logic sar_start;
    logic sar_abort;
    conv_cfg_s cfg;
    logic wr0;
    logic wr1;

    // R5 clock selection
    function automatic logic [7:0] div_of(input logic high, input logic low);
        if (high) begin
            return `DIV_F1;
        end
        return low ? `DIV_F2 : `DIV_F4;
    endfunction

    // R1 channel decode
    function automatic logic [3:0] pin_of(input logic [2:0] ch, input logic grp);
        logic [3:0] sel;
        sel = 4'h0;
        // R2 group gating
        if (grp && ch[2]) begin
            sel[ch[1:0]] = 1'b1;
        end
        return sel;
    endfunction

    assign wr0 = bus.wr && bus.addr == `OFS_CTRL_ZERO;
    assign wr1 = bus.wr && bus.addr == `OFS_CTRL_ONE;

    always_comb begin
        cfg.channel = cur.ctrl0[`C0_CH_LSB +: 3];
        cfg.group_en = cur.ctrl0[`C0_GROUP];
        cfg.trig_timer = cur.ctrl0[`C0_TRIG];
        cfg.res_ten = cur.ctrl1[`C1_RES];
        cfg.div = div_of(cur.ctrl1[`C1_CKHIGH], cur.ctrl0[`C0_CKLOW]);
    end

    // R4 start trigger
    assign sar_start = (cur.state == ST_WAIT_TRIG)
        && (!cfg.trig_timer || timer_req) && cur.ctrl0[`C0_START];
    // R11 halt on clear
    assign sar_abort = !cur.ctrl0[`C0_START];

    adc_clock_gen u_clock_gen (
        .clock(clock),
        .rstn(rstn),
        .run(cur.state == ST_CONVERT),
        .div(cfg.div),
        .tick(tick)
    );

    adc_sar_core u_sar (
        .clock(clock),
        .rstn(rstn),
        .start(sar_start),
        .abort(sar_abort),
        .tick(tick),
        .res_ten(cfg.res_ten),
        .comp_high(comp_high),
        .trial(sar_trial),
        .done(sar_done),
        .value(sar_value)
    );

    always_comb begin
        next_cur = cur;
        next_cur.irq = 1'b0;
        next_cur.rdata = 8'h00;
        next_cur.fresh = 1'b0;
        next_cur.trial = sar_trial;
        // R7 writes land even mid-conversion
        if (wr0) begin
            next_cur.ctrl0 = bus.wdata;
        end
        if (wr1) begin
            next_cur.ctrl1 = bus.wdata & `CTRL_ONE_WMASK;
        end
        // R10 settle count restarts on a connect edge
        if (!next_cur.ctrl1[`C1_REF]) begin
            next_cur.settle = 8'h00;
        end else if (!cur.ctrl1[`C1_REF]) begin
            next_cur.settle = 8'(`REF_SETTLE_CYC);
        end else if (cur.settle != 8'h00) begin
            next_cur.settle = cur.settle - 8'h01;
        end
        next_cur.ready = next_cur.ctrl1[`C1_REF] && next_cur.settle == 8'h00;
        next_cur.in_sel = pin_of(cfg.channel, cfg.group_en);
        case (cur.state)
            ST_IDLE: begin
                if (cur.ctrl0[`C0_START]) begin
                    next_cur.state = ST_WAIT_TRIG;
                end
            end
            ST_WAIT_TRIG: begin
                if (!cur.ctrl0[`C0_START]) begin
                    next_cur.state = ST_IDLE;
                end else if (sar_start) begin
                    next_cur.state = ST_CONVERT;
                end
            end
            ST_CONVERT: begin
                if (!cur.ctrl0[`C0_START]) begin
                    // R11 software stop
                    next_cur.state = ST_IDLE;
                end else if (sar_done) begin
                    // R16 R17 latest value overwrites
                    next_cur.result = sar_value;
                    next_cur.fresh = 1'b1;
                    // R3 mode bit selects
                    if (cur.ctrl0[`C0_MODE]) begin
                        // R15 repeat rearms
                        next_cur.state = ST_WAIT_TRIG;
                    end else begin
                        // R12 R13 R14 one-shot ends
                        next_cur.state = ST_IDLE;
                        next_cur.irq = 1'b1;
                        if (!wr0) begin
                            next_cur.ctrl0[`C0_START] = 1'b0;
                        end
                    end
                end
            end
            default: begin
                next_cur.state = ST_IDLE;
            end
        endcase
        if (bus.rd) begin
            case (bus.addr)
                `OFS_CTRL_ZERO: next_cur.rdata = cur.ctrl0;
                `OFS_CTRL_ONE: next_cur.rdata = cur.ctrl1;
                `OFS_RESULT_LO: next_cur.rdata = cur.result[7:0];
                `OFS_RESULT_HI: next_cur.rdata = {6'h00, cur.result[9:8]};
                `OFS_STATUS: next_cur.rdata = {6'h00, cur.settle == 8'h00,
                    cur.state == ST_CONVERT};
                default: next_cur.rdata = 8'h00;
            endcase
        end
    end

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            cur <= '0;
            cur.ctrl0 <= `CTRL_ZERO_RESET;
            cur.ctrl1 <= `CTRL_ONE_RESET;
            cur.state <= ST_IDLE;
        end else begin
            cur <= next_cur;
        end
    end

    assign rdata = cur.rdata;
    assign input_select = cur.in_sel;
    assign dac_trial = cur.trial;
    assign reference_connect = cur.ctrl1[`C1_REF];
    assign ref_ready = cur.ready;
    assign conv_irq = cur.irq;

    // R14 request only when one-shot completes
    a_irq_oneshot: assert property (@(posedge clock) disable iff (!rstn) // R14
        conv_irq |-> !$past(cur.ctrl0[`C0_MODE]) && $past(sar_done))
        else $error("completion request without one-shot done");
    // R13 flag self clears
    a_flag_clear: assert property (@(posedge clock) disable iff (!rstn) // R13
        conv_irq && !$past(wr0) |-> !cur.ctrl0[`C0_START])
        else $error("start flag not cleared after one-shot");
    // R16 result loads on completion
    a_result_load: assert property (@(posedge clock) disable iff (!rstn) // R16
        cur.fresh |-> cur.result == $past(sar_value))
        else $error("result not loaded");
    // R15 repeat keeps running
    a_repeat_rearm: assert property (@(posedge clock) disable iff (!rstn) // R15
        cur.fresh && cur.ctrl0[`C0_MODE] && cur.ctrl0[`C0_START]
        |-> cur.state == ST_WAIT_TRIG)
        else $error("repeat did not rearm");
    // R11 stop halts
    a_stop_halt: assert property (@(posedge clock) disable iff (!rstn) // R11
        cur.state == ST_CONVERT && !cur.ctrl0[`C0_START] |=> cur.state == ST_IDLE)
        else $error("conversion not halted");
    // R2 group gating
    a_group_gate: assert property (@(posedge clock) disable iff (!rstn) // R2
        !$past(cfg.group_en) |-> input_select == 4'h0)
        else $error("input selected while group disabled");
    // R4 timer trigger
    a_timer_trig: assert property (@(posedge clock) disable iff (!rstn) // R4
        cur.state == ST_WAIT_TRIG && cfg.trig_timer && !timer_req
        |=> cur.state != ST_CONVERT)
        else $error("timer start without request");
    // R10 settle time
    a_ref_settle: assert property (@(posedge clock) disable iff (!rstn) // R10
        $rose(reference_connect) |-> !ref_ready [*8])
        else $error("reference ready too early");
    // R14 single-cycle request
    a_irq_pulse: assert property (@(posedge clock) disable iff (!rstn) // R14
        conv_irq |=> !conv_irq)
        else $error("completion request longer than one cycle");
    // R14 repeat stays quiet
    a_repeat_quiet: assert property (@(posedge clock) disable iff (!rstn) // R14
        $past(cur.ctrl0[`C0_MODE]) |-> !conv_irq)
        else $error("completion request in repeat");
    // R12 one-shot ends idle
    a_oneshot_idle: assert property (@(posedge clock) disable iff (!rstn) // R12
        conv_irq |-> cur.state == ST_IDLE)
        else $error("one-shot did not stop");
    // R1 legal codes decode
    a_channel_decode: assert property (@(posedge clock) disable iff (!rstn) // R1
        cfg.group_en && cfg.channel[2]
        |=> input_select == (4'h1 << $past(cfg.channel[1:0])))
        else $error("wrong analog input selected");
    // R1 other codes select nothing
    a_channel_off: assert property (@(posedge clock) disable iff (!rstn) // R1
        !cfg.channel[2] |=> input_select == 4'h0)
        else $error("input selected for an unused code");
    // R1 at most one input
    a_select_onehot: assert property (@(posedge clock) disable iff (!rstn) // R1
        $onehot0(input_select))
        else $error("more than one input selected");
    // R10 no readiness while disconnected
    a_ref_off: assert property (@(posedge clock) disable iff (!rstn) // R10
        !reference_connect |-> !ref_ready)
        else $error("reference ready while disconnected");
    // R16 result only changes on completion
    a_result_hold: assert property (@(posedge clock) disable iff (!rstn) // R16
        !cur.fresh |-> $stable(cur.result))
        else $error("result changed without completion");
    // R9 8-bit results end in zeros
    a_res_eight: assert property (@(posedge clock) disable iff (!rstn) // R9
        cur.fresh && !$past(cfg.res_ten) |-> cur.result[1:0] == 2'b00)
        else $error("8-bit result with low bits set");
    // R4 software trigger starts at once
    a_soft_start: assert property (@(posedge clock) disable iff (!rstn) // R4
        cur.state == ST_WAIT_TRIG && !cfg.trig_timer && cur.ctrl0[`C0_START]
        |=> cur.state == ST_CONVERT)
        else $error("software start ignored");
    // R4 timer request starts
    a_timer_start: assert property (@(posedge clock) disable iff (!rstn) // R4
        cur.state == ST_WAIT_TRIG && cfg.trig_timer && timer_req && cur.ctrl0[`C0_START]
        |=> cur.state == ST_CONVERT)
        else $error("timer request ignored");
    // R11 cleared flag never converts
    a_stop_no_conv: assert property (@(posedge clock) disable iff (!rstn) // R11
        !cur.ctrl0[`C0_START] |=> cur.state != ST_CONVERT)
        else $error("conversion without start flag");
endmodule
`default_nettype wire

// ==== tb/adc_control_oneshot_repeat_bench.sv ====
// Self-checking bench for the converter control block.
// Assumes the design files and the register map header on the include path.
`timescale 1ns/1ps
`default_nettype none
`include "adc_ctrl_map.svh"
module adc_control_oneshot_repeat_bench;
    import adc_ctrl_pkg::*;
    localparam int LIMIT = 10000;
    logic clock = 1'b0;
    logic rstn = 1'b0;
    bus_req_s bus = '0;
    logic timer_req = 1'b0;
    logic comp_high = 1'b1;
    logic [7:0] rdata;
    logic [3:0] input_select;
    logic [9:0] dac_trial;
    logic reference_connect;
    logic ref_ready;
    logic conv_irq;
    int num_errors = 0;
    int samples_checked = 0;
    int cycles = 0;
    int irq_count = 0;

    always #5 clock = ~clock;

    adc_control i_dut (
        .clock(clock),
        .rstn(rstn),
        .bus(bus),
        .rdata(rdata),
        .timer_req(timer_req),
        .comp_high(comp_high),
        .input_select(input_select),
        .dac_trial(dac_trial),
        .reference_connect(reference_connect),
        .ref_ready(ref_ready),
        .conv_irq(conv_irq)
    );

    task automatic close_out();
        $display("Checks made %0d, mismatches %0d", samples_checked, num_errors);
        if (num_errors == 0 && samples_checked > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    // Hang guard and completion pulse counter
    always @(posedge clock) begin
        cycles <= cycles + 1;
        if (conv_irq === 1'b1) begin
            irq_count <= irq_count + 1;
        end
        if (cycles == LIMIT) begin
            num_errors++;
            $display("Error at %0t: run did not finish", $time);
            close_out();
        end
    end

    task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
        samples_checked++;
        if (got !== exp) begin
            num_errors++;
            $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clock);
        bus <= '{a, d, 1'b1, 1'b0};
        @(posedge clock);
        bus <= '0;
    endtask

    // Read data stand only in the cycle after the read edge
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clock);
        bus <= '{a, 8'h00, 1'b0, 1'b1};
        @(posedge clock);
        bus <= '0;
        #1;
        d = rdata;
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp, input string what);
        logic [7:0] d;
        rd(a, d);
        chk(d, exp, what);
    endtask

    task automatic rd_result(output logic [9:0] v);
        logic [7:0] lo;
        logic [7:0] hi;
        rd(`OFS_RESULT_LO, lo);
        rd(`OFS_RESULT_HI, hi);
        v = {hi[1:0], lo};
    endtask

    task automatic wait_cycles(input int k);
        repeat (k) @(posedge clock);
        #1;
    endtask

    task automatic wait_irq(input int lim, output int n);
        n = 0;
        while (n < lim) begin
            @(posedge clock);
            #1;
            n++;
            if (conv_irq === 1'b1) begin
                break;
            end
        end
    endtask

    initial begin
        logic [7:0] d;
        logic [9:0] v;
        logic [3:0] e;
        logic [7:0] c0;
        logic [7:0] c1;
        int n;
        int base;
        int div;
        int cyc;
        repeat (3) @(posedge clock);
        rstn <= 1'b1;
        rd_chk(`OFS_CTRL_ZERO, `CTRL_ZERO_RESET, "ctrl0 reset");
        rd_chk(`OFS_CTRL_ONE, `CTRL_ONE_RESET, "ctrl1 reset");
        wr(8'hE0, 8'hFF);
        rd_chk(8'hE0, 8'h00, "unmapped read");
        wr(`OFS_CTRL_ONE, 8'hFF);
        rd_chk(`OFS_CTRL_ONE, `CTRL_ONE_WMASK, "ctrl1 writable bits");
        wr(`OFS_CTRL_ONE, 8'h00);
        wr(`OFS_CTRL_ONE, 8'h20);
        wait_cycles(`REF_SETTLE_CYC - 10);
        chk(reference_connect, 1'b1, "reference connected");
        chk(ref_ready, 1'b0, "reference still settling");
        wait_cycles(18);
        chk(ref_ready, 1'b1, "reference settled");
        rd_chk(`OFS_STATUS, 8'h02, "status settled idle");
        for (int ch = 0; ch < 8; ch++) begin
            e = (ch >= 4) ? (4'h1 << (ch - 4)) : 4'h0;
            wr(`OFS_CTRL_ZERO, ((ch >= 4) ? 8'h10 : 8'h00) | 8'(4 + ch % 4));
            wait_cycles(2);
            chk(input_select, e, "channel decode");
        end
        wr(`OFS_CTRL_ZERO, 8'h07);
        wait_cycles(2);
        chk(input_select, 4'h0, "group disabled");
        // Every divider at both resolutions, one-shot, software start
        for (int k = 0; k < 6; k++) begin
            div = (k % 3 == 0) ? `DIV_F1 : (k % 3 == 1) ? `DIV_F2 : `DIV_F4;
            cyc = (k >= 3) ? `CONV_CYC_10 : `CONV_CYC_8;
            c1 = 8'h20 | ((k >= 3) ? 8'h08 : 8'h00) | ((k % 3 == 0) ? 8'h10 : 8'h00);
            c0 = 8'h54 | ((k % 3 == 1) ? 8'h80 : 8'h00);
            wr(`OFS_CTRL_ONE, c1);
            base = irq_count;
            wr(`OFS_CTRL_ZERO, c0);
            wait_irq(cyc * div + 40, n);
            chk(n >= cyc * div && n <= cyc * div + 8, 1'b1, "conversion time");
            wait_cycles(1);
            rd_chk(`OFS_CTRL_ZERO, c0 & 8'hBF, "start self clear");
            rd_result(v);
            chk(v, (k >= 3) ? 10'h3FF : 10'h3FC, "one-shot result");
            wait_cycles(100);
            chk(irq_count - base, 1, "one request per start");
        end
        // Halt a one-shot in mid-conversion
        wr(`OFS_CTRL_ONE, 8'h30);
        base = irq_count;
        wr(`OFS_CTRL_ZERO, 8'h54);
        wait_cycles(20);
        chk(dac_trial, 10'h3FF, "trial bits accepted");
        wr(`OFS_CTRL_ZERO, 8'h14);
        wait_cycles(150);
        chk(irq_count - base, 0, "halted one-shot");
        rd_chk(`OFS_STATUS, 8'h02, "not converting");
        // Timer trigger
        wr(`OFS_CTRL_ZERO, 8'h74);
        wait_cycles(80);
        chk(irq_count - base, 0, "waits for timer");
        @(posedge clock);
        timer_req <= 1'b1;
        @(posedge clock);
        timer_req <= 1'b0;
        wait_irq(100, n);
        chk(n < 100, 1'b1, "timer started conversion");
        // Repeat mode, channel set again after the mode change
        wr(`OFS_CTRL_ZERO, 8'h1C);
        base = irq_count;
        wr(`OFS_CTRL_ZERO, 8'h5C);
        wait_cycles(200);
        chk(irq_count - base, 0, "no request in repeat");
        rd_result(v);
        chk(v, 10'h3FC, "repeat result");
        @(posedge clock);
        comp_high <= 1'b0;
        wait_cycles(150);
        rd_result(v);
        chk(v, 10'h000, "repeat overwrites");
        wr(`OFS_CTRL_ZERO, 8'h1C);
        wait_cycles(10);
        @(posedge clock);
        comp_high <= 1'b1;
        wait_cycles(150);
        rd_result(v);
        chk(v, 10'h000, "repeat stopped");
        rd_chk(`OFS_CTRL_ZERO, 8'h1C, "start stays clear");
        chk(irq_count - base, 0, "no request after stop");
        close_out();
    end
endmodule
`default_nettype wire
